// ===== rtl/adc_pkg.sv
/*
  Constants shared by the converter control logic: register offsets,
  control field layout, divider codes, event bits and state codes.
  Assumes an 8-bit register port with byte offsets.
*/
package adc_pkg;

  // register offsets
  localparam logic [7:0] RESULT_HI_ADDR = 8'hFA;
  localparam logic [7:0] RESULT_LO_ADDR = 8'hFB;
  localparam logic [7:0] CTRL_ADDR = 8'hFC;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h20;
  localparam logic [7:0] IRQ_EN_ADDR = 8'h21;
  localparam logic [7:0] IRQ_CLR_ADDR = 8'h22;

  // control register layout and reset value
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 4;
  localparam int EOC_BIT = 3;
  localparam int DIV_MSB = 2;
  localparam int DIV_LSB = 1;
  localparam int START_BIT = 0;
  localparam logic [3:0] SEL_LAST = 4'h8;
  localparam logic [3:0] SEL_RESET = 4'h0;

  // divider codes and tick masks
  localparam logic [1:0] DIV16 = 2'h0;
  localparam logic [1:0] DIV8 = 2'h1;
  localparam logic [1:0] DIV4 = 2'h2;
  localparam logic [1:0] DIV1 = 2'h3;
  localparam logic [1:0] DIV_RESET = 2'h0;
  localparam logic [3:0] MASK16 = 4'hF;
  localparam logic [3:0] MASK8 = 4'h7;
  localparam logic [3:0] MASK4 = 4'h3;
  localparam logic [3:0] MASK1 = 4'h0;

  // interrupt event bits
  localparam int NUM_EV = 2;
  localparam int EV_DONE = 0;
  localparam int EV_RESTART = 1;
  localparam logic [1:0] EV_RESET = 2'h0;

  // converter clock ticks per conversion
  localparam int CONV_TICKS_DEF = 12;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } conv_state_e;

endpackage : adc_pkg

// ===== rtl/adc_ctrl.sv
/*
  Converter control and status logic: control register, input select,
  converter clock divider, conversion sequencer, result bytes and a
  masked interrupt.
  Assumes a synchronous register port with read data one cycle later,
  oscillator tick enables synchronous to mclk, and a converter core that
  presents its sample on conv_data when the last tick is counted.
*/
`timescale 1ns/1ns
`default_nettype none

module adc_ctrl #(
  parameter int RES_W = 10,
  parameter int CONV_TICKS = adc_pkg::CONV_TICKS_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // system clock sources
  input wire logic main_osc_tick,
  input wire logic sub_osc_tick,
  input wire logic sub_osc_sel,
  // analog multiplexer and converter core
  output logic [3:0] mux_sel,
  output logic mux_gnd,
  output logic conv_clk_en,
  output logic conv_busy,
  input wire logic [RES_W-1:0] conv_data,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic [3:0] sel_q;
  logic [3:0] mux_sel_q;
  logic mux_gnd_q;
  logic [1:0] div_q;
  logic eoc_q;
  logic [3:0] div_cnt_q;
  logic [3:0] div_mask;
  logic fxx_tick;
  logic conv_tick;
  adc_pkg::conv_state_e state_q;
  logic [15:0] tick_cnt_q;
  logic last_tick;
  logic [RES_W-1:0] result_q;
  logic [15:0] res_wide;
  logic [adc_pkg::NUM_EV-1:0] stat_q;
  logic [adc_pkg::NUM_EV-1:0] en_q;
  logic [adc_pkg::NUM_EV-1:0] ev;
  logic [7:0] rdata_q;
  logic [7:0] ctrl_rd;
  logic wr_ctrl;
  logic start_req;
  logic finish;

  ////////////////////////////////////////////////////////////////////////
  // register decode

  // control write and start request
  assign wr_ctrl = reg_wr && (reg_addr == adc_pkg::CTRL_ADDR);
  assign start_req = wr_ctrl && reg_wdata[adc_pkg::START_BIT];

  // control register readback, start bit reads as zero
  assign ctrl_rd = {sel_q, eoc_q, div_q, 1'b0};

  // control fields, result and status bits keep their own flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_q <= adc_pkg::SEL_RESET;
      div_q <= adc_pkg::DIV_RESET;
    end else if (wr_ctrl) begin
      sel_q <= reg_wdata[adc_pkg::SEL_MSB:adc_pkg::SEL_LSB];
      div_q <= reg_wdata[adc_pkg::DIV_MSB:adc_pkg::DIV_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input multiplexer

  // route inputs 0..8, ground for any other code
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mux_sel_q <= adc_pkg::SEL_RESET;
      mux_gnd_q <= 1'b0;
    end else if (wr_ctrl) begin
      if (reg_wdata[adc_pkg::SEL_MSB:adc_pkg::SEL_LSB] > adc_pkg::SEL_LAST) begin
        mux_sel_q <= adc_pkg::SEL_RESET;
        mux_gnd_q <= 1'b1;
      end else begin
        mux_sel_q <= reg_wdata[adc_pkg::SEL_MSB:adc_pkg::SEL_LSB];
        mux_gnd_q <= 1'b0;
      end
    end
  end

  assign mux_sel = mux_sel_q;
  assign mux_gnd = mux_gnd_q;

  ////////////////////////////////////////////////////////////////////////
  // converter clock divider

  // system clock tick from the selected oscillator
  assign fxx_tick = sub_osc_sel ? sub_osc_tick : main_osc_tick;

  // mask of low divider bits that must all be set for a tick
  always_comb begin
    unique case (div_q)
      adc_pkg::DIV16: div_mask = adc_pkg::MASK16;
      adc_pkg::DIV8: div_mask = adc_pkg::MASK8;
      adc_pkg::DIV4: div_mask = adc_pkg::MASK4;
      adc_pkg::DIV1: div_mask = adc_pkg::MASK1;
    endcase
  end

  // free-running prescaler counted in system clock ticks
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= 4'h0;
    end else if (fxx_tick) begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  assign conv_tick = fxx_tick && ((div_cnt_q & div_mask) == div_mask);
  assign conv_clk_en = conv_tick;

  ////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  assign last_tick = (tick_cnt_q == 16'(CONV_TICKS - 1));
  assign finish = (state_q == adc_pkg::ST_RUN) && conv_tick && last_tick &&
    !start_req;

  // idle until started, count converter ticks, then finish
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= adc_pkg::ST_IDLE;
      tick_cnt_q <= 16'h0000;
    end else if (start_req) begin
      state_q <= adc_pkg::ST_RUN;
      tick_cnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        adc_pkg::ST_IDLE: begin
          tick_cnt_q <= 16'h0000;
        end
        adc_pkg::ST_RUN: begin
          if (finish) begin
            state_q <= adc_pkg::ST_IDLE;
          end else if (conv_tick) begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
          end
        end
        default: begin
          state_q <= adc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign conv_busy = (state_q == adc_pkg::ST_RUN);

  // done flag clears on start, sets with the captured result
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eoc_q <= 1'b0;
    end else if (start_req) begin
      eoc_q <= 1'b0;
    end else if (finish) begin
      eoc_q <= 1'b1;
    end
  end

  // result is loaded only by the sequencer, never by a write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_q <= '0;
    end else if (finish) begin
      result_q <= conv_data;
    end
  end

  // result left-justified over the two bytes
  assign res_wide = 16'(result_q) << (16 - RES_W);

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, enable and clear

  assign ev[adc_pkg::EV_DONE] = finish;
  assign ev[adc_pkg::EV_RESTART] = start_req && conv_busy;

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stat_q <= adc_pkg::EV_RESET;
    end else if (reg_wr && (reg_addr == adc_pkg::IRQ_CLR_ADDR)) begin
      stat_q <= (stat_q & ~reg_wdata[adc_pkg::NUM_EV-1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  // interrupt enable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      en_q <= adc_pkg::EV_RESET;
    end else if (reg_wr && (reg_addr == adc_pkg::IRQ_EN_ADDR)) begin
      en_q <= reg_wdata[adc_pkg::NUM_EV-1:0];
    end
  end

  assign irq = |(stat_q & en_q);

  ////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the read strobe

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        adc_pkg::RESULT_HI_ADDR: rdata_q <= res_wide[15:8];
        adc_pkg::RESULT_LO_ADDR: rdata_q <= res_wide[7:0];
        adc_pkg::CTRL_ADDR: rdata_q <= ctrl_rd;
        adc_pkg::IRQ_STAT_ADDR: rdata_q <= 8'(stat_q);
        adc_pkg::IRQ_EN_ADDR: rdata_q <= 8'(en_q);
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // assertions and their helper logic

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic [4:0] div_ratio;
  logic [4:0] gap_q;
  logic gap_ok_q;
  logic seen_q;

  // expected division ratio of the current setting
  always_comb begin
    unique case (div_q)
      adc_pkg::DIV16: div_ratio = 5'h10;
      adc_pkg::DIV8: div_ratio = 5'h08;
      adc_pkg::DIV4: div_ratio = 5'h04;
      adc_pkg::DIV1: div_ratio = 5'h01;
    endcase
  end

  // system ticks since the last converter tick under a stable setting
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gap_q <= 5'h00;
      gap_ok_q <= 1'b0;
    end else if (wr_ctrl) begin
      gap_q <= 5'h00;
      gap_ok_q <= 1'b0;
    end else if (conv_tick) begin
      gap_q <= 5'h00;
      gap_ok_q <= 1'b1;
    end else if (fxx_tick) begin
      gap_q <= gap_q + 5'h01;
    end
  end

  // first cycle after reset release
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  sequence s_start;
    start_req;
  endsequence

  sequence s_finish;
    conv_busy && conv_tick && last_tick && !start_req;
  endsequence

  AST_SEL_ROUTE: assert property (
    wr_ctrl && (reg_wdata[7:4] <= adc_pkg::SEL_LAST)
    |=> (mux_sel == $past(reg_wdata[7:4])) && !mux_gnd)
    else $error("selected input not routed");

  AST_SEL_GROUND: assert property (
    wr_ctrl && (reg_wdata[7:4] > adc_pkg::SEL_LAST) |=> mux_gnd)
    else $error("illegal selector not grounded");

  AST_EOC_RUN: assert property (
    s_start |=> !eoc_q throughout (conv_busy [*2]) or !conv_busy)
    else $error("done flag set during conversion");

  AST_EOC_READ: assert property (
    reg_rd && (reg_addr == adc_pkg::CTRL_ADDR)
    |=> reg_rdata[adc_pkg::EOC_BIT] == $past(eoc_q))
    else $error("done bit readback wrong");

  AST_DIV_RATIO: assert property (
    conv_tick && gap_ok_q && !wr_ctrl |-> (gap_q + 5'h01) == div_ratio)
    else $error("converter clock ratio wrong");

  AST_START: assert property (
    s_start |=> conv_busy && (tick_cnt_q == 16'h0000))
    else $error("start did not begin conversion");

  AST_NO_START: assert property (
    wr_ctrl && !reg_wdata[0] && !conv_busy |=> !conv_busy)
    else $error("conversion began without start");

  AST_RESULT_RO: assert property (
    reg_wr && !finish |=> $stable(result_q))
    else $error("result changed by a write");

  AST_CTRL_RESET: assert property (
    !seen_q |-> ctrl_rd == adc_pkg::CTRL_RESET)
    else $error("control register not zero after reset");

  AST_CLK_SOURCE: assert property (
    (sub_osc_sel ? !sub_osc_tick : !main_osc_tick)
    |-> !conv_tick ##1 $stable(div_cnt_q))
    else $error("divider moved without a selected oscillator tick");

  AST_DONE_RESULT: assert property (
    s_finish |=> eoc_q && (result_q == $past(conv_data)) && !conv_busy)
    else $error("done flag and result not together");

endmodule : adc_ctrl

`default_nettype wire

// ===== tb/analog_src.sv
/*
  Model of the analog pins behind the input multiplexer.
  Assumes the converter samples conv_data while conv_clk_en is high.
*/
`timescale 1ns/1ns
`default_nettype none

module analog_src #(
  parameter int RES_W = 10
) (
  // multiplexer control
  input wire logic [3:0] mux_sel,
  input wire logic mux_gnd,
  input wire logic conv_clk_en,
  // sampled level
  output logic [RES_W-1:0] conv_data
);
  logic [RES_W-1:0] lvl;

  // each pin has its own level; a grounded input reads zero
  always_comb begin
    lvl = mux_gnd ? '0 : RES_W'(10'h0C3 + 10'(mux_sel) * 10'h045);
    // off the tick the line is not settled, so show the inverse
    conv_data = conv_clk_en ? lvl : ~lvl;
  end
endmodule : analog_src

`default_nettype wire

// ===== tb/tb_top.sv
/*
  Self-checking bench for the converter control logic.
  Assumes a 100 MHz mclk and a short conversion of two converter ticks.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic mclk, rst, reg_wr, reg_rd, main_osc_tick, sub_osc_tick, sub_osc_sel;
  logic mux_gnd, conv_clk_en, conv_busy, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] rv;
  logic [3:0] mux_sel;
  logic [9:0] conv_data;
  logic [1:0] ph = 2'h0;
  int err_total, total_checks;

  adc_ctrl #(.RES_W(10), .CONV_TICKS(2)) dut (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_osc_tick(main_osc_tick),
    .sub_osc_tick(sub_osc_tick), .sub_osc_sel(sub_osc_sel),
    .mux_sel(mux_sel), .mux_gnd(mux_gnd), .conv_clk_en(conv_clk_en),
    .conv_busy(conv_busy), .conv_data(conv_data), .irq(irq));
  analog_src #(.RES_W(10)) src (.mux_sel(mux_sel), .mux_gnd(mux_gnd),
    .conv_clk_en(conv_clk_en), .conv_data(conv_data));

  ////////////////////////////////////////////////////////////////////////////
  // clock and oscillator ticks: main every cycle, sub every fourth
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    ph <= ph + 2'h1;
    main_osc_tick <= 1'b1;
    sub_osc_tick <= (ph == 2'h3);
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared bus cycles and comparison
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rv = 16'(reg_rdata);
    @(posedge mclk);
  endtask : rd
  task automatic wait_done;
    int n;
    n = 0;
    while (conv_busy !== 1'b0 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    chk(16'(n < 300), 16'h1);
    @(posedge mclk);
  endtask : wait_done
  // cycles between two converter ticks
  task automatic gap(input logic [1:0] dv, input int exp);
    int n;
    wr(adc_pkg::CTRL_ADDR, {4'h0, 1'b0, dv, 1'b0});
    n = 0;
    while (conv_clk_en !== 1'b1 && n < 100) @(negedge mclk) n++;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (conv_clk_en !== 1'b1 && n < 100);
    chk(16'(n), 16'(exp));
    @(posedge mclk);
  endtask : gap

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    rd(adc_pkg::CTRL_ADDR);
    chk(rv, 16'h00);
    chk(16'({mux_gnd, irq, conv_busy}), 16'h0);
    rd(8'h40);
    chk(rv, 16'h00);
  endtask : t_reset
  task automatic t_select;
    logic [9:0] e;
    for (int c = 0; c < 16; c++) begin
      e = (c > 8) ? 10'h000 : 10'(10'h0C3 + c * 10'h045);
      wr(adc_pkg::CTRL_ADDR, {4'(c), 4'h5});
      wait_done();
      chk(16'({mux_gnd, mux_sel}), (c > 8) ? 16'h10 : 16'(c));
      rd(adc_pkg::RESULT_HI_ADDR);
      chk(rv, 16'(e[9:2]));
      rd(adc_pkg::RESULT_LO_ADDR);
      chk(rv, 16'({e[1:0], 6'h00}));
      rd(adc_pkg::CTRL_ADDR);
      chk(rv, 16'({4'(c), 4'hC}));
    end
  endtask : t_select
  task automatic t_div;
    gap(adc_pkg::DIV16, 16);
    gap(adc_pkg::DIV8, 8);
    gap(adc_pkg::DIV4, 4);
    gap(adc_pkg::DIV1, 1);
    sub_osc_sel <= 1'b1;
    gap(adc_pkg::DIV1, 4);
    gap(adc_pkg::DIV4, 16);
    sub_osc_sel <= 1'b0;
  endtask : t_div
  task automatic t_eoc;
    wr(adc_pkg::CTRL_ADDR, 8'h21);
    rd(adc_pkg::CTRL_ADDR);
    chk(rv, 16'h20);
    chk(16'(conv_busy), 16'h1);
    wait_done();
    wr(adc_pkg::CTRL_ADDR, 8'h30);
    rd(adc_pkg::CTRL_ADDR);
    chk(rv, 16'h38);
    chk(16'(conv_busy), 16'h0);
    wr(adc_pkg::RESULT_HI_ADDR, 8'hFF);
    wr(adc_pkg::RESULT_LO_ADDR, 8'hFF);
    rd(adc_pkg::RESULT_HI_ADDR);
    chk(rv, 16'h53);
    rd(adc_pkg::RESULT_LO_ADDR);
    chk(rv, 16'h40);
  endtask : t_eoc
  task automatic t_irq;
    wr(adc_pkg::IRQ_CLR_ADDR, 8'h03);
    wr(adc_pkg::IRQ_EN_ADDR, 8'h01);
    wr(adc_pkg::CTRL_ADDR, 8'h07);
    wait_done();
    @(posedge mclk);
    chk(16'(irq), 16'h1);
    wr(adc_pkg::IRQ_EN_ADDR, 8'h00);
    chk(16'(irq), 16'h0);
    rd(adc_pkg::IRQ_STAT_ADDR);
    chk(rv, 16'h01);
    wr(adc_pkg::IRQ_CLR_ADDR, 8'h01);
    wr(adc_pkg::IRQ_EN_ADDR, 8'h02);
    chk(16'(irq), 16'h0);
    wr(adc_pkg::CTRL_ADDR, 8'h01);
    wr(adc_pkg::CTRL_ADDR, 8'h01);
    rd(adc_pkg::IRQ_STAT_ADDR);
    chk(rv, 16'h02);
    chk(16'(irq), 16'h1);
    wait_done();
    wr(adc_pkg::IRQ_CLR_ADDR, 8'h03);
    chk(16'(irq), 16'h0);
  endtask : t_irq

  ////////////////////////////////////////////////////////////////////////////
  // verdict, watchdog and main sequence
  task automatic test_done;
    if (err_total == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    #300000;
    err_total++;
    test_done();
  end
  initial begin
    err_total = 0;
    total_checks = 0;
    rst = 1'b1;
    {reg_wr, reg_rd, sub_osc_sel} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_select();
    t_div();
    t_eoc();
    t_irq();
    test_done();
  end
endmodule : tb_top

`default_nettype wire
